// file: common/wkm_pkg.sv
// Constants and types for the watchdog key, monitor select and self-test flag registers
package wkm_pkg;
	localparam int FRAME_W = 16;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 11;
	localparam int TYPE_BIT = 10;
	localparam int DATA_HI = 8;
	localparam int DATA_LO = 1;
	localparam logic TYPE_WRITE = 1'h1;
	localparam logic [4:0] ADDR_KEY = 5'h0B;
	localparam logic [4:0] ADDR_MUX = 5'h0C;
	localparam logic [4:0] ADDR_VFY0 = 5'h0D;
	localparam logic [4:0] ADDR_VFY1 = 5'h0E;
	localparam logic [7:0] KEY_FIRST = 8'hD3;
	localparam logic [7:0] KEY_SECOND = 8'h33;
	localparam logic [7:0] KEY_FLASH = 8'hCC;
	localparam logic [7:0] KEY_CONFIG = 8'hCD;
	localparam logic [7:0] KEY_RESTART = 8'hCE;
	localparam logic [7:0] KEY_DISABLE = 8'hCF;
	localparam int ACT_FLASH = 0;
	localparam int ACT_CONFIG = 1;
	localparam int ACT_RESTART = 2;
	localparam int ACT_DISABLE = 3;
	localparam logic [3:0] MUX_RESET = 4'h0;
	localparam logic [3:0] MUX_LAST = 4'hB;
	localparam logic [7:0] VFY0_RESET = 8'h00;
	localparam logic [3:0] VFY1_RESET = 4'h0;
	localparam logic [15:0] REPLY_RESET = 16'h0000;
	// Flag positions in the main result register
	localparam int VFY0_SELFTEST = 7;
	localparam int VFY0_THERMAL = 6;
	localparam int VFY0_PREREG_OV = 5;
	localparam int VFY0_PREREG_UV = 4;
	localparam int VFY0_MCU_OV = 3;
	localparam int VFY0_MCU_UV = 2;
	localparam int VFY0_GEN_OV = 1;
	localparam int VFY0_GEN_UV = 0;
	// Flag positions in the sensor result register
	localparam int VFY1_S1_OV = 3;
	localparam int VFY1_S1_UV = 2;
	localparam int VFY1_S2_OV = 1;
	localparam int VFY1_S2_UV = 0;

	typedef enum logic [2:0] {
		KEY_IDLE = 3'b001,
		KEY_GOT1 = 3'b010,
		KEY_GOT2 = 3'b100
	} wkm_key_step_t;

	// Odd parity: bit that makes the whole frame's one count odd
	function automatic logic wkm_parity_bit(logic [14:0] upper);
		return ~(^upper);
	endfunction
endpackage

// file: core/wkm_regs.sv
// Watchdog unlock key, analog monitor select and self-test result registers
`timescale 1ns/1ps
module wkm_regs (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	input wire logic [7:0] check_failed_main,
	input wire logic [3:0] check_failed_sensor,
	output logic flash_mode_req,
	output logic config_mode_req,
	output logic wd_restart_req,
	output logic wd_disable_req,
	output logic [3:0] monitor_select,
	output logic monitor_route_en,
	output logic [7:0] selftest_result_main,
	output logic [3:0] selftest_result_sensor
);
	typedef struct packed {
		wkm_pkg::wkm_key_step_t key_step;
		logic [3:0] act;
		logic [3:0] mux_sel;
		logic route_en;
		logic [7:0] vfy0;
		logic [3:0] vfy1;
		logic [15:0] reply;
	} wkm_regs_st_t;

	wkm_regs_st_t st;
	wkm_regs_st_t next_st;
	logic rx_valid;
	logic [15:0] rx_word;
	logic [4:0] addr;
	logic is_write;
	logic [7:0] data;
	logic par_ok;
	logic frame_ok;
	logic key_wr;
	logic mux_wr;
	logic [7:0] clr0;
	logic [3:0] clr1;
	logic [7:0] rd_data;
	logic [14:0] reply_upper;

	// One register written by a good frame
	function automatic logic wr_hit(input logic ok, input logic wr, input logic [4:0] a,
		input logic [4:0] target);
		return ok & wr & (a == target);
	endfunction

	wkm_spi_frame i_wkm_spi_frame (
		.mclk(mclk),
		.rst_n(rst_n),
		.sck(spi_sck),
		.cs_n(spi_cs_n),
		.mosi(spi_mosi),
		.tx_word(st.reply),
		.miso(spi_miso),
		.miso_oe(spi_miso_oe),
		.rx_valid(rx_valid),
		.rx_word(rx_word)
	);

	// Frame fields
	assign addr = rx_word[wkm_pkg::ADDR_HI:wkm_pkg::ADDR_LO];
	assign is_write = rx_word[wkm_pkg::TYPE_BIT] == wkm_pkg::TYPE_WRITE;
	assign data = rx_word[wkm_pkg::DATA_HI:wkm_pkg::DATA_LO];
	assign par_ok = rx_word[0] == wkm_pkg::wkm_parity_bit(rx_word[15:1]);
	assign frame_ok = rx_valid & par_ok;
	assign key_wr = wr_hit(frame_ok, is_write, addr, wkm_pkg::ADDR_KEY);
	assign mux_wr = wr_hit(frame_ok, is_write, addr, wkm_pkg::ADDR_MUX);
	assign clr0 = wr_hit(frame_ok, is_write, addr, wkm_pkg::ADDR_VFY0) ? data : 8'h00;
	assign clr1 = wr_hit(frame_ok, is_write, addr, wkm_pkg::ADDR_VFY1) ? data[3:0] : 4'h0;

	always_comb begin
		next_st = st;
		next_st.act = 4'h0;
		rd_data = 8'h00;
		reply_upper = 15'h0000;
		// Unlock sequence
		if (key_wr) begin
			unique case (st.key_step)
				wkm_pkg::KEY_IDLE: begin
					if (data == wkm_pkg::KEY_FIRST) begin
						next_st.key_step = wkm_pkg::KEY_GOT1;
					end
				end
				wkm_pkg::KEY_GOT1: begin
					if (data == wkm_pkg::KEY_SECOND) begin
						next_st.key_step = wkm_pkg::KEY_GOT2;
					end else begin
						next_st.key_step = wkm_pkg::KEY_IDLE;
					end
				end
				wkm_pkg::KEY_GOT2: begin
					next_st.key_step = wkm_pkg::KEY_IDLE;
					if (data == wkm_pkg::KEY_FLASH) begin
						next_st.act[wkm_pkg::ACT_FLASH] = 1'b1;
					end else if (data == wkm_pkg::KEY_CONFIG) begin
						next_st.act[wkm_pkg::ACT_CONFIG] = 1'b1;
					end else if (data == wkm_pkg::KEY_RESTART) begin
						next_st.act[wkm_pkg::ACT_RESTART] = 1'b1;
					end else if (data == wkm_pkg::KEY_DISABLE) begin
						next_st.act[wkm_pkg::ACT_DISABLE] = 1'b1;
					end
				end
				default: begin
					next_st.key_step = wkm_pkg::KEY_IDLE;
				end
			endcase
		end
		// Monitor select and its routing qualifier
		if (mux_wr) begin
			next_st.mux_sel = data[3:0];
		end
		next_st.route_en = next_st.mux_sel <= wkm_pkg::MUX_LAST;
		// Result flags: a failure in the clearing cycle still lands
		next_st.vfy0 = (st.vfy0 & ~clr0) | check_failed_main;
		next_st.vfy1 = (st.vfy1 & ~clr1) | check_failed_sensor;
		// Reply for the next frame
		if (rx_valid) begin
			next_st.reply = wkm_pkg::REPLY_RESET;
			if (par_ok && !is_write) begin
				if (addr == wkm_pkg::ADDR_KEY) begin
					rd_data = 8'h00;
				end else if (addr == wkm_pkg::ADDR_MUX) begin
					rd_data = {4'h0, st.mux_sel};
				end else if (addr == wkm_pkg::ADDR_VFY0) begin
					rd_data = st.vfy0;
				end else if (addr == wkm_pkg::ADDR_VFY1) begin
					rd_data = {4'h0, st.vfy1};
				end
				if (addr >= wkm_pkg::ADDR_KEY && addr <= wkm_pkg::ADDR_VFY1) begin
					reply_upper = {addr, 1'b0, 1'b0, rd_data};
					next_st.reply = {reply_upper, wkm_pkg::wkm_parity_bit(reply_upper)};
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{key_step: wkm_pkg::KEY_IDLE, act: 4'h0, mux_sel: wkm_pkg::MUX_RESET,
				route_en: 1'b1, vfy0: wkm_pkg::VFY0_RESET, vfy1: wkm_pkg::VFY1_RESET,
				reply: wkm_pkg::REPLY_RESET};
		end else begin
			st <= next_st;
		end
	end

	assign flash_mode_req = st.act[wkm_pkg::ACT_FLASH];
	assign config_mode_req = st.act[wkm_pkg::ACT_CONFIG];
	assign wd_restart_req = st.act[wkm_pkg::ACT_RESTART];
	assign wd_disable_req = st.act[wkm_pkg::ACT_DISABLE];
	assign monitor_select = st.mux_sel;
	assign monitor_route_en = st.route_en;
	assign selftest_result_main = st.vfy0;
	assign selftest_result_sensor = st.vfy1;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	parity_drop_a: assert property (
		rx_valid && !par_ok |=> $stable(st.key_step) && $stable(monitor_select)
			&& st.reply == 16'h0000)
		else $error("bad parity frame changed state");
	key_read_a: assert property (
		frame_ok && !is_write && addr == wkm_pkg::ADDR_KEY
			|=> st.reply[8:1] == 8'h00 && st.reply[15:11] == 5'h0B)
		else $error("key register read returned content");
	key_first_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_IDLE && data == 8'hD3
			|=> st.key_step == wkm_pkg::KEY_GOT1)
		else $error("first unlock word not taken");
	key_second_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT1 && data == 8'h33
			|=> st.key_step == wkm_pkg::KEY_GOT2)
		else $error("second unlock word not taken");
	action_map_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT2 && data[7:2] == 6'h33
			|=> st.act == 4'(1 << $past(data[1:0])) ##1 st.act == 4'h0)
		else $error("action word gave wrong strobe");
	action_cause_a: assert property (
		st.act != 4'h0 |-> $past(st.key_step) == wkm_pkg::KEY_GOT2 && $past(key_wr))
		else $error("action strobe without full sequence");
	key_abort_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT1 && data != 8'h33
			|=> st.key_step == wkm_pkg::KEY_IDLE && st.act == 4'h0)
		else $error("wrong unlock word did not restart");
	key_third_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT2 |=> st.key_step == wkm_pkg::KEY_IDLE)
		else $error("sequence not closed after third word");
	mux_write_a: assert property (
		mux_wr |=> monitor_select == $past(data[3:0]) ##1 $stable(monitor_select) || $past(mux_wr))
		else $error("monitor select not written");
	route_code_a: assert property (
		monitor_route_en == (monitor_select < 4'hC))
		else $error("reserved code routed or valid code blocked");
	sensor_clear_a: assert property (
		clr1 != 4'h0 |=> (selftest_result_sensor & $past(clr1) & ~$past(check_failed_sensor))
			== 4'h0)
		else $error("sensor flag not cleared");

	// Unlock sequence guards
	key_idle_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_IDLE && data != wkm_pkg::KEY_FIRST
			|=> st.key_step == wkm_pkg::KEY_IDLE)
		else $error("stray word left the idle step");
	key_hold_a: assert property (
		!key_wr |=> $stable(st.key_step))
		else $error("key step moved without a key write");
	key_onehot_a: assert property (
		$onehot(st.key_step))
		else $error("key step code illegal");
	act_quiet_a: assert property (
		!key_wr |=> st.act == 4'h0)
		else $error("action strobe without a key write");
	strobe_onehot_a: assert property (
		$onehot0(st.act))
		else $error("more than one action strobe");
	strobe_pulse_a: assert property (
		st.act != 4'h0 |=> st.act == 4'h0)
		else $error("action strobe longer than one cycle");
	key_wrong3_a: assert property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT2 && data[7:2] != 6'h33
			|=> st.act == 4'h0)
		else $error("wrong action word gave a strobe");

	// Register select and read-back guards
	mux_hold_a: assert property (
		!mux_wr |=> $stable(monitor_select))
		else $error("monitor select changed without a write");
	mux_read_a: assert property (
		frame_ok && !is_write && addr == wkm_pkg::ADDR_MUX
			|=> st.reply[wkm_pkg::DATA_HI:wkm_pkg::DATA_LO] == {4'h0, $past(monitor_select)})
		else $error("monitor select read-back wrong");
	main_read_a: assert property (
		frame_ok && !is_write && addr == wkm_pkg::ADDR_VFY0
			|=> st.reply[wkm_pkg::DATA_HI:wkm_pkg::DATA_LO] == $past(selftest_result_main))
		else $error("main result read-back wrong");
	sensor_read_a: assert property (
		frame_ok && !is_write && addr == wkm_pkg::ADDR_VFY1
			|=> st.reply[wkm_pkg::DATA_HI:wkm_pkg::DATA_LO]
				== {4'h0, $past(selftest_result_sensor)})
		else $error("sensor result read-back wrong");
	reply_addr_a: assert property (
		frame_ok && !is_write && addr >= wkm_pkg::ADDR_KEY && addr <= wkm_pkg::ADDR_VFY1
			|=> st.reply[wkm_pkg::ADDR_HI:wkm_pkg::ADDR_LO] == $past(addr))
		else $error("reply carries wrong address");
	reply_parity_a: assert property (
		st.reply == 16'h0000 || (^st.reply) == 1'b1)
		else $error("reply frame parity not odd");
	write_reply_a: assert property (
		rx_valid && is_write |=> st.reply == 16'h0000)
		else $error("write frame left a reply");
	unmapped_reply_a: assert property (
		rx_valid && (addr < wkm_pkg::ADDR_KEY || addr > wkm_pkg::ADDR_VFY1)
			|=> st.reply == 16'h0000)
		else $error("unmapped read gave a reply");
	miso_idle_a: assert property (
		!spi_miso_oe |-> !spi_miso)
		else $error("reply line active outside a frame");

	// Per-flag set, clear and hold
	for (genvar i = 0; i < 8; i++) begin : g_main_flag
		main_set_a: assert property (
			check_failed_main[i] |=> selftest_result_main[i])
			else $error("main failure flag lost");
		main_clear_a: assert property (
			clr0[i] && !check_failed_main[i] |=> !selftest_result_main[i])
			else $error("main flag not cleared");
		main_hold_a: assert property (
			!clr0[i] && selftest_result_main[i] |=> selftest_result_main[i])
			else $error("main flag dropped without clear");
		main_rise_a: assert property (
			$rose(selftest_result_main[i]) |-> $past(check_failed_main[i]))
			else $error("main flag set without a failure");
	end

	// Sensor flags likewise
	for (genvar j = 0; j < 4; j++) begin : g_sensor_flag
		sensor_set_a: assert property (
			check_failed_sensor[j] |=> selftest_result_sensor[j])
			else $error("sensor failure flag lost");
		sensor_bit_clear_a: assert property (
			clr1[j] && !check_failed_sensor[j] |=> !selftest_result_sensor[j])
			else $error("sensor flag bit not cleared");
		sensor_hold_a: assert property (
			!clr1[j] && selftest_result_sensor[j] |=> selftest_result_sensor[j])
			else $error("sensor flag dropped without clear");
		sensor_rise_a: assert property (
			$rose(selftest_result_sensor[j]) |-> $past(check_failed_sensor[j]))
			else $error("sensor flag set without a failure");
	end

	unlock_flash_c: cover property (
		key_wr && data == 8'hD3 ##[1:300] key_wr ##[1:300] key_wr ##1 flash_mode_req);
	disable_c: cover property (wd_disable_req);
	clear_race_c: cover property (clr0[7] && check_failed_main[7]);
	reserved_c: cover property (mux_wr ##1 !monitor_route_en);
	// Sequence broken at the second word
	key_abort_c: cover property (
		key_wr && st.key_step == wkm_pkg::KEY_GOT1 && data != wkm_pkg::KEY_SECOND);
endmodule // wkm_regs

// file: core/wkm_spi_frame.sv
// Serial frame receiver and reply shifter, oversampled on the system clock
`timescale 1ns/1ps
module wkm_spi_frame (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic [15:0] tx_word,
	output logic miso,
	output logic miso_oe,
	output logic rx_valid,
	output logic [15:0] rx_word
);
	typedef struct packed {
		logic [2:0] sck_s;
		logic [2:0] cs_s;
		logic [2:0] mosi_s;
		logic sck_f;
		logic cs_f;
		logic mosi_f;
		logic [15:0] shift;
		logic [4:0] cnt;
		logic [15:0] tx;
		logic miso;
		logic oe;
		logic valid;
	} wkm_spi_st_t;

	wkm_spi_st_t st;
	wkm_spi_st_t next_st;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	always_comb begin
		next_st = st;
		next_st.valid = 1'b0;
		next_st.sck_s = {st.sck_s[1:0], sck};
		next_st.cs_s = {st.cs_s[1:0], cs_n};
		next_st.mosi_s = {st.mosi_s[1:0], mosi};
		// A pin change counts once stages two and three agree
		if (st.sck_s[1] == st.sck_s[2]) begin
			next_st.sck_f = st.sck_s[2];
		end
		if (st.cs_s[1] == st.cs_s[2]) begin
			next_st.cs_f = st.cs_s[2];
		end
		if (st.mosi_s[1] == st.mosi_s[2]) begin
			next_st.mosi_f = st.mosi_s[2];
		end
		sck_rise = next_st.sck_f & ~st.sck_f;
		sck_fall = ~next_st.sck_f & st.sck_f;
		cs_fall = ~next_st.cs_f & st.cs_f;
		cs_rise = next_st.cs_f & ~st.cs_f;
		if (cs_fall) begin
			next_st.cnt = 5'h00;
			next_st.tx = tx_word;
			next_st.miso = tx_word[15];
			next_st.oe = 1'b1;
		end else if (!next_st.cs_f) begin
			if (sck_rise) begin
				next_st.shift = {st.shift[14:0], next_st.mosi_f};
				if (st.cnt != 5'h1F) begin
					next_st.cnt = st.cnt + 5'h01;
				end
			end
			if (sck_fall) begin
				next_st.tx = {st.tx[14:0], 1'b0};
				next_st.miso = st.tx[14];
			end
		end
		if (cs_rise) begin
			next_st.oe = 1'b0;
			next_st.miso = 1'b0;
			// Only whole 16-bit frames are handed on
			if (st.cnt == 5'(wkm_pkg::FRAME_W)) begin
				next_st.valid = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '{sck_s: 3'h0, cs_s: 3'h7, mosi_s: 3'h0, sck_f: 1'b0, cs_f: 1'b1,
				mosi_f: 1'b0, shift: 16'h0000, cnt: 5'h00, tx: 16'h0000,
				miso: 1'b0, oe: 1'b0, valid: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign miso = st.miso;
	assign miso_oe = st.oe;
	assign rx_valid = st.valid;
	assign rx_word = st.shift;

	frame_len_a: assert property (@(posedge mclk) disable iff (!rst_n)
		rx_valid |-> $past(st.cnt) == 5'h10 && st.cs_f)
		else $error("frame accepted with wrong bit count");
	oe_frame_a: assert property (@(posedge mclk) disable iff (!rst_n)
		miso_oe |-> !st.cs_f)
		else $error("reply driven outside a frame");
endmodule // wkm_spi_frame

// file: sim/testbench.sv
// Self-checking bench for key, monitor select and self-test registers
`timescale 1ns/1ps
module testbench;
	logic mclk;
	logic rst_n;
	logic sck;
	logic cs_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic [7:0] fail_main;
	logic [3:0] fail_sensor;
	logic [3:0] strobe;
	logic [3:0] mon_sel;
	logic route_en;
	logic [7:0] res_main;
	logic [3:0] res_sensor;
	logic [7:0] pulses [4];
	int n_fail;
	int tests_run;

	wkm_regs i_wkm_regs (.mclk(mclk), .rst_n(rst_n), .spi_sck(sck), .spi_cs_n(cs_n),
		.spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(miso_oe), .check_failed_main(fail_main),
		.check_failed_sensor(fail_sensor), .flash_mode_req(strobe[0]),
		.config_mode_req(strobe[1]), .wd_restart_req(strobe[2]), .wd_disable_req(strobe[3]),
		.monitor_select(mon_sel), .monitor_route_en(route_en),
		.selftest_result_main(res_main), .selftest_result_sensor(res_sensor));
	wkm_host i_wkm_host (.mclk(mclk), .miso(miso), .miso_oe(miso_oe), .sck(sck), .cs_n(cs_n),
		.mosi(mosi));

	initial mclk = 1'h0;
	always #4 mclk = ~mclk;

	// Counts high cycles of each action strobe
	always @(posedge mclk) begin
		for (int k = 0; k < 4; k++) begin
			if (strobe[k] === 1'h1) begin
				pulses[k] <= pulses[k] + 8'h01;
			end
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		i_wkm_host.xfer(a, 1'h1, d, 1'h0, 16);
	endtask

	// Read, then fetch the reply with a second frame
	task automatic rd(input logic [4:0] a, input logic [15:0] exp);
		i_wkm_host.xfer(a, 1'h0, 8'h00, 1'h0, 16);
		i_wkm_host.xfer(5'h1F, 1'h0, 8'h00, 1'h0, 16);
		chk(i_wkm_host.reply, exp);
	endtask

	function automatic logic [15:0] rep(input logic [4:0] a, input logic [7:0] d);
		return {a, 2'h0, d, ~(^{a, d})};
	endfunction

	task automatic key3(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		wr(wkm_pkg::ADDR_KEY, x);
		wr(wkm_pkg::ADDR_KEY, y);
		wr(wkm_pkg::ADDR_KEY, z);
	endtask

	task automatic t_reset();
		chk(16'({miso_oe, miso}), 16'h0000);
		chk(16'(mon_sel), 16'h0000);
		chk(16'(route_en), 16'h0001);
		chk(16'(res_main), 16'h0000);
		chk(16'(res_sensor), 16'h0000);
		rd(wkm_pkg::ADDR_MUX, rep(wkm_pkg::ADDR_MUX, 8'h00));
		$display("test reset done");
	endtask

	task automatic t_mux();
		for (int c = 0; c < 16; c++) begin
			wr(wkm_pkg::ADDR_MUX, 8'(c));
			chk(16'(mon_sel), 16'(c));
			chk(16'(route_en), 16'(c < 12));
		end
		rd(wkm_pkg::ADDR_MUX, rep(wkm_pkg::ADDR_MUX, 8'h0F));
		wr(5'h10, 8'h03);
		chk(16'(mon_sel), 16'h000F);
		rd(5'h10, 16'h0000);
		$display("test mux done");
	endtask

	task automatic t_key();
		logic [7:0] act [4];
		act = '{wkm_pkg::KEY_FLASH, wkm_pkg::KEY_CONFIG, wkm_pkg::KEY_RESTART,
			wkm_pkg::KEY_DISABLE};
		for (int k = 0; k < 4; k++) begin
			key3(wkm_pkg::KEY_FIRST, wkm_pkg::KEY_SECOND, act[k]);
			chk(16'(pulses[k]), 16'h0001);
		end
		key3(wkm_pkg::KEY_FIRST, wkm_pkg::KEY_FIRST, wkm_pkg::KEY_SECOND);
		wr(wkm_pkg::ADDR_KEY, wkm_pkg::KEY_FLASH);
		key3(wkm_pkg::KEY_FIRST, wkm_pkg::KEY_SECOND, 8'hCB);
		key3(wkm_pkg::KEY_SECOND, wkm_pkg::KEY_DISABLE, wkm_pkg::KEY_FIRST);
		wr(wkm_pkg::ADDR_MUX, 8'h02);
		i_wkm_host.xfer(wkm_pkg::ADDR_KEY, 1'h1, 8'h00, 1'h1, 16);
		i_wkm_host.xfer(wkm_pkg::ADDR_KEY, 1'h1, 8'h00, 1'h0, 15);
		wr(wkm_pkg::ADDR_KEY, wkm_pkg::KEY_SECOND);
		wr(wkm_pkg::ADDR_KEY, wkm_pkg::KEY_RESTART);
		chk({pulses[3], pulses[2]}, 16'h0102);
		chk({pulses[1], pulses[0]}, 16'h0101);
		rd(wkm_pkg::ADDR_KEY, rep(wkm_pkg::ADDR_KEY, 8'h00));
		$display("test key done");
	endtask

	task automatic t_flags();
		fail_main <= 8'hA5;
		fail_sensor <= 4'h9;
		@(posedge mclk);
		fail_main <= 8'h00;
		fail_sensor <= 4'h0;
		repeat (3) @(posedge mclk);
		chk(16'(res_main), 16'h00A5);
		chk(16'(res_sensor), 16'h0009);
		rd(wkm_pkg::ADDR_VFY0, rep(wkm_pkg::ADDR_VFY0, 8'hA5));
		rd(wkm_pkg::ADDR_VFY1, rep(wkm_pkg::ADDR_VFY1, 8'h09));
		i_wkm_host.xfer(wkm_pkg::ADDR_VFY0, 1'h1, 8'hFF, 1'h1, 16);
		chk(16'(res_main), 16'h00A5);
		i_wkm_host.xfer(wkm_pkg::ADDR_VFY0, 1'h1, 8'hFF, 1'h0, 15);
		chk(16'(res_main), 16'h00A5);
		wr(wkm_pkg::ADDR_VFY0, 8'h81);
		chk(16'(res_main), 16'h0024);
		wr(wkm_pkg::ADDR_VFY1, 8'h08);
		chk(16'(res_sensor), 16'h0001);
		// Remaining flag bits, then a failure held through a clear
		fail_main <= 8'h5A;
		fail_sensor <= 4'h6;
		@(posedge mclk);
		fail_main <= 8'h80;
		fail_sensor <= 4'h0;
		repeat (3) @(posedge mclk);
		chk(16'(res_main), 16'h00FE);
		chk(16'(res_sensor), 16'h0007);
		wr(wkm_pkg::ADDR_VFY0, 8'hFF);
		chk(16'(res_main), 16'h0080);
		fail_main <= 8'h00;
		wr(wkm_pkg::ADDR_VFY0, 8'h80);
		wr(wkm_pkg::ADDR_VFY1, 8'h0F);
		chk({res_main, 4'h0, res_sensor}, 16'h0000);
		$display("test flags done");
	endtask

	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge mclk);
		n_fail++;
		test_done();
	end

	initial begin
		rst_n = 1'h0;
		fail_main = 8'h00;
		fail_sensor = 4'h0;
		pulses = '{default: 8'h00};
		n_fail = 0;
		tests_run = 0;
		repeat (20) @(posedge mclk);
		rst_n <= 1'h1;
		repeat (2) @(posedge mclk);
		t_reset();
		t_mux();
		t_key();
		t_flags();
		test_done();
	end
endmodule // testbench

// file: sim/wkm_host.sv
// Host serial master model driving frames into the register block
`timescale 1ns/1ps
module wkm_host (
	input wire logic mclk,
	input wire logic miso,
	input wire logic miso_oe,
	output logic sck,
	output logic cs_n,
	output logic mosi
);
	logic [15:0] reply;

	initial begin
		sck = 1'h0;
		cs_n = 1'h1;
		mosi = 1'h0;
		reply = 16'h0000;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge mclk);
	endtask

	// One frame of nbits, MSB first; bad flips the parity
	task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d,
		input logic bad, input int nbits);
		logic [15:0] f;
		f = {a, w, 1'h0, d, 1'h0};
		f[0] = ~(^f[15:1]) ^ bad;
		reply = 16'h0000;
		cs_n <= 1'h0;
		for (int i = 15; i > 15 - nbits; i--) begin
			wait_clk(5);
			sck <= 1'h0;
			mosi <= f[i];
			wait_clk(5);
			// Undriven reply line reads as its inverse
			reply[i] = miso_oe ? miso : ~miso;
			sck <= 1'h1;
		end
		wait_clk(5);
		sck <= 1'h0;
		wait_clk(5);
		cs_n <= 1'h1;
		// Released data line must not keep its last level
		mosi <= ~mosi;
		wait_clk(12);
	endtask
endmodule // wkm_host
